// ### rtl/identify_map.vh
`ifndef IDENTIFY_MAP_VH
`define IDENTIFY_MAP_VH

// ****************************************************************
// Identify byte layout
// ****************************************************************
`define ID_FLAG_BIT        7
`define ID_GRANT_BIT       6
`define ID_TRS_BIT         5
`define ID_RSV_HI_BIT      4
`define ID_RSV_LO_BIT      3
`define ID_LUN_HI_BIT      2
`define ID_LUN_LO_BIT      0
`define ID_SUPPORTED_LUN   3'h0
`define ID_TX_BASE         8'h80

// ****************************************************************
// Bus phase codes seen by the handler
// ****************************************************************
`define PH_SELECT          4'h0
`define PH_COMMAND         4'h1
`define PH_DATA_OUT        4'h2
`define PH_DATA_IN         4'h3
`define PH_STATUS          4'h4
`define PH_MSG_OUT         4'h5
`define PH_AFTER_CMD_DONE  4'h6
`define PH_AFTER_DISC      4'h7
`define PH_AFTER_REJECT    4'h8
`define PH_AFTER_RESTORE   4'h9
`define PH_AFTER_IDENTIFY  4'hA

// ****************************************************************
// Command opcodes and answers for an unsupported unit
// ****************************************************************
`define OP_INQUIRY         8'h12
`define OP_REQUEST_SENSE   8'h03
`define INQ_NO_DEVICE      8'h7F
`define SK_ILLEGAL_REQ     4'h5
`define ASC_LUN_UNSUPP     8'h25
`define ASCQ_ZERO          8'h00

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define REG_CTRL           8'h00
`define REG_STATE          8'h04
`define REG_INT_STATUS     8'h08
`define REG_INT_MASK       8'h0C
`define REG_LAST_MSG       8'h10

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define CTRL_ENABLE_BIT    0
`define CTRL_DROP_BIT      1
`define CTRL_RESET         32'h0000_0001
`define INT_W              5
`define INT_FIRST_BIT      0
`define INT_INVALID_BIT    1
`define INT_MISMATCH_BIT   2
`define INT_BUS_FREE_BIT   3
`define INT_LUN_UNSUPP_BIT 4
`define INT_MASK_RESET     5'h00
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ### rtl/identify_decode.v
`timescale 1ns/1ps
`default_nettype none
`include "identify_map.vh"

module identify_decode (
	input  wire [7:0] msg_byte_in,
	output wire       is_identify_out,
	output wire       grant_out,
	output wire       valid_out,
	output wire [2:0] lun_out
);

	// ****************************************************************
	// Field extraction
	// ****************************************************************
	wire trs_set;
	wire rsv_set;

	// Top bit alone marks the message kind
	assign is_identify_out = msg_byte_in[`ID_FLAG_BIT];
	assign grant_out       = msg_byte_in[`ID_GRANT_BIT];
	assign trs_set         = msg_byte_in[`ID_TRS_BIT];
	assign rsv_set         = msg_byte_in[`ID_RSV_HI_BIT] | msg_byte_in[`ID_RSV_LO_BIT];
	assign lun_out         = msg_byte_in[`ID_LUN_HI_BIT:`ID_LUN_LO_BIT];

	// Either routine select or reserved bits spoil the byte
	assign valid_out = is_identify_out & ~trs_set & ~rsv_set;

endmodule
`default_nettype wire

// ### rtl/identify_message_handler.v
// Overview of operation
// - Byte with top bit set is Identify
// - Bit six grants or forbids disconnect
// - Own Identify byte sends grant zero
// - Unit number from low bits, unit zero
// - Other unit: check condition for commands
// - Inquiry on other unit: no device
// - Request sense other unit: unit unsupported
// - Reserved or routine select set: invalid
// - Disconnect once per long command
// - First valid Identify in selection latches grant, unit
// - Repeat during selection updates grant
// - Repeat in transfer phases: continue
// - Repeat after command complete: bus free
// - After disconnect: update, stay or free
// - After reject, restore, identify: update, continue
`timescale 1ns/1ps
`default_nettype none
`include "identify_map.vh"

module identify_message_handler (
	input  wire        sys_clk_in,
	input  wire        rst_n_in,
	input  wire        ce_in,
	// Message path
	input  wire        msg_valid_in,
	input  wire [7:0]  msg_byte_in,
	input  wire [3:0]  bus_phase_in,
	input  wire        conn_end_in,
	// Command path
	input  wire        cmd_valid_in,
	input  wire [7:0]  cmd_opcode_in,
	input  wire        cmd_done_in,
	input  wire        disc_taken_in,
	// AXI4-Lite slave
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Results
	output reg         process_messages_out,
	output reg         disconnect_grant_bit_out,
	output reg  [2:0]  lun_out,
	output reg         continue_out,
	output reg         bus_free_out,
	output reg         invalid_identify_out,
	output reg         lun_mismatch_out,
	output reg         check_condition_out,
	output reg  [3:0]  sense_key_out,
	output reg  [7:0]  sense_asc_out,
	output reg  [7:0]  sense_ascq_out,
	output reg  [7:0]  inquiry_byte0_out,
	output reg         inquiry_override_out,
	output wire        disconnect_ok_out,
	output wire        hold_connection_out,
	output wire [7:0]  tx_identify_out,
	output wire        irq_out
);

	// ****************************************************************
	// Byte decode
	// ****************************************************************
	wire       dec_is_id;
	wire       dec_grant;
	wire       dec_valid;
	wire [2:0] dec_lun;

	identify_decode u_decode (
		.msg_byte_in     (msg_byte_in),
		.is_identify_out (dec_is_id),
		.grant_out       (dec_grant),
		.valid_out       (dec_valid),
		.lun_out         (dec_lun)
	);

	// ****************************************************************
	// Register storage
	// ****************************************************************
	reg  [31:0]         ctrl;
	reg  [`INT_W-1:0]   int_status;
	reg  [`INT_W-1:0]   int_mask;
	reg  [7:0]          last_msg;
	reg                 disc_used;
	reg  [`INT_W-1:0]   events;
	wire                enable;
	wire                id_event;
	wire                same_lun;

	assign enable   = ctrl[`CTRL_ENABLE_BIT];
	assign id_event = enable & msg_valid_in & dec_is_id;
	assign same_lun = (dec_lun == lun_out);

	// ****************************************************************
	// Identify handling by phase
	// ****************************************************************
	reg       next_pm;
	reg       next_grant;
	reg [2:0] next_lun;
	reg       next_cont;
	reg       next_free;
	reg       next_inv;
	reg       next_mis;

	// Phase table for a repeat with the same unit
	always @* begin
		next_pm    = process_messages_out;
		next_grant = disconnect_grant_bit_out;
		next_lun   = lun_out;
		next_cont  = 1'b0;
		next_free  = 1'b0;
		next_inv   = 1'b0;
		next_mis   = 1'b0;
		if (id_event) begin
			if (!dec_valid) begin
				next_inv = 1'b1;
			end else if (!process_messages_out) begin
				// Only selection opens the message system
				if (bus_phase_in == `PH_SELECT) begin
					next_pm    = 1'b1;
					next_grant = dec_grant;
					next_lun   = dec_lun;
				end
			end else if (!same_lun) begin
				next_mis = 1'b1;
			end else begin
				case (bus_phase_in)
					`PH_SELECT: begin
						next_grant = dec_grant;
					end
					`PH_COMMAND, `PH_DATA_OUT, `PH_DATA_IN, `PH_STATUS, `PH_MSG_OUT: begin
						next_cont = 1'b1;
					end
					`PH_AFTER_CMD_DONE: begin
						next_free = 1'b1;
					end
					`PH_AFTER_DISC: begin
						next_grant = dec_grant;
						next_cont  = ~dec_grant;
						next_free  = dec_grant;
					end
					`PH_AFTER_REJECT, `PH_AFTER_RESTORE, `PH_AFTER_IDENTIFY: begin
						next_grant = dec_grant;
						next_cont  = 1'b1;
					end
					default: begin
						next_cont = 1'b0;
					end
				endcase
			end
		end
		// Leaving the bus ends the connection state
		if (next_free || conn_end_in || ctrl[`CTRL_DROP_BIT]) begin
			next_pm = 1'b0;
		end
	end

	// Connection state and one-cycle results
	always @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			process_messages_out     <= 1'b0;
			disconnect_grant_bit_out <= 1'b0;
			lun_out                  <= `ID_SUPPORTED_LUN;
			continue_out             <= 1'b0;
			bus_free_out             <= 1'b0;
			invalid_identify_out     <= 1'b0;
			lun_mismatch_out         <= 1'b0;
			last_msg                 <= 8'h00;
		end else if (ce_in) begin
			process_messages_out     <= next_pm;
			disconnect_grant_bit_out <= next_grant;
			lun_out                  <= next_lun;
			continue_out             <= next_cont;
			bus_free_out             <= next_free;
			invalid_identify_out     <= next_inv;
			lun_mismatch_out         <= next_mis;
			if (id_event) begin
				last_msg <= msg_byte_in;
			end
		end
	end

	// ****************************************************************
	// Disconnect bookkeeping
	// ****************************************************************
	// One disconnect per command; cleared when the command ends
	always @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			disc_used <= 1'b0;
		end else if (ce_in) begin
			if (cmd_done_in || !process_messages_out) begin
				disc_used <= 1'b0;
			end else if (disc_taken_in) begin
				disc_used <= 1'b1;
			end
		end
	end

	assign disconnect_ok_out   = process_messages_out & disconnect_grant_bit_out & ~disc_used;
	assign hold_connection_out = process_messages_out & ~disconnect_grant_bit_out;
	// Own Identify on reselection never offers a grant
	assign tx_identify_out     = `ID_TX_BASE | {5'h00, lun_out};

	// ****************************************************************
	// Commands to an unsupported unit
	// ****************************************************************
	wire lun_bad;
	wire cmd_event;

	assign lun_bad   = process_messages_out & (lun_out != `ID_SUPPORTED_LUN);
	assign cmd_event = enable & cmd_valid_in & lun_bad;

	// Sense stays until reset so a later request sense can read it
	always @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			check_condition_out  <= 1'b0;
			inquiry_override_out <= 1'b0;
			inquiry_byte0_out    <= 8'h00;
			sense_key_out        <= 4'h0;
			sense_asc_out        <= 8'h00;
			sense_ascq_out       <= 8'h00;
		end else if (ce_in) begin
			check_condition_out  <= 1'b0;
			inquiry_override_out <= 1'b0;
			if (cmd_event) begin
				sense_key_out  <= `SK_ILLEGAL_REQ;
				sense_asc_out  <= `ASC_LUN_UNSUPP;
				sense_ascq_out <= `ASCQ_ZERO;
				case (cmd_opcode_in)
					`OP_INQUIRY: begin
						inquiry_override_out <= 1'b1;
						inquiry_byte0_out    <= `INQ_NO_DEVICE;
					end
					`OP_REQUEST_SENSE: begin
						inquiry_override_out <= 1'b0;
					end
					default: begin
						check_condition_out <= 1'b1;
					end
				endcase
			end
		end
	end

	// ****************************************************************
	// Interrupt events
	// ****************************************************************
	always @* begin
		events = {`INT_W{1'b0}};
		events[`INT_FIRST_BIT]      = ~process_messages_out & next_pm;
		events[`INT_INVALID_BIT]    = next_inv;
		events[`INT_MISMATCH_BIT]   = next_mis;
		events[`INT_BUS_FREE_BIT]   = next_free;
		events[`INT_LUN_UNSUPP_BIT] = cmd_event;
	end

	assign irq_out = |(int_status & int_mask);

	// ****************************************************************
	// AXI4-Lite write channel
	// ****************************************************************
	reg        aw_held;
	reg        w_held;
	reg [7:0]  aw_addr;
	reg [31:0] w_data;
	reg [3:0]  w_strb;
	wire       wr_fire;
	wire [31:0] strb_mask;

	// Address and data may arrive in either order
	assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
	assign wr_fire       = aw_held & w_held & ~s_axi_bvalid;
	assign strb_mask     = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

	always @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= 8'h00;
			w_data       <= 32'h0000_0000;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
		end else if (ce_in) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (aw_addr)
					`REG_CTRL, `REG_STATE, `REG_INT_STATUS, `REG_INT_MASK,
					`REG_LAST_MSG: s_axi_bresp <= `RESP_OKAY;
					default: s_axi_bresp <= `RESP_SLVERR;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Register updates; a new event beats a same-cycle clear
	always @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			ctrl       <= `CTRL_RESET;
			int_status <= {`INT_W{1'b0}};
			int_mask   <= `INT_MASK_RESET;
		end else if (ce_in) begin
			// Drop request is a one-shot
			ctrl[`CTRL_DROP_BIT] <= 1'b0;
			if (wr_fire && aw_addr == `REG_CTRL) begin
				ctrl <= (ctrl & ~strb_mask) | (w_data & strb_mask);
			end
			if (wr_fire && aw_addr == `REG_INT_MASK) begin
				int_mask <= (int_mask & ~strb_mask[`INT_W-1:0]) | (w_data[`INT_W-1:0] & strb_mask[`INT_W-1:0]);
			end
			if (wr_fire && aw_addr == `REG_INT_STATUS) begin
				int_status <= (int_status & ~(w_data[`INT_W-1:0] & strb_mask[`INT_W-1:0])) | events;
			end else begin
				int_status <= int_status | events;
			end
		end
	end

	// ****************************************************************
	// AXI4-Lite read channel
	// ****************************************************************
	reg [31:0] rd_word;
	reg        rd_hit;

	assign s_axi_arready = ~s_axi_rvalid;

	always @* begin
		rd_word = 32'h0000_0000;
		rd_hit  = 1'b1;
		case (s_axi_araddr)
			`REG_CTRL:       rd_word = ctrl & 32'h0000_0001;
			`REG_STATE:      rd_word = {24'h00_0000, disc_used, lun_bad, lun_out,
						hold_connection_out, disconnect_grant_bit_out, process_messages_out};
			`REG_INT_STATUS: rd_word = {27'h000_0000, int_status};
			`REG_INT_MASK:   rd_word = {27'h000_0000, int_mask};
			`REG_LAST_MSG:   rd_word = {24'h00_0000, last_msg};
			default:         rd_hit  = 1'b0;
		endcase
	end

	// Answer one cycle after the address is taken
	always @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `RESP_OKAY;
		end else if (ce_in) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_word;
				s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule
`default_nettype wire

// ### bench/identify_message_handler_props.sv
`timescale 1ns/1ps
`default_nettype none
module identify_message_handler_props (
	input wire logic       sys_clk_in, rst_n_in, ce_in, msg_valid_in, conn_end_in, cmd_valid_in,
	input wire logic       process_messages_out, disconnect_grant_bit_out, continue_out,
	input wire logic       bus_free_out, invalid_identify_out, check_condition_out,
	input wire logic       inquiry_override_out, disconnect_ok_out, hold_connection_out,
	input wire logic [7:0] msg_byte_in, cmd_opcode_in, sense_asc_out, inquiry_byte0_out,
	input wire logic [7:0] tx_identify_out,
	input wire logic [3:0] bus_phase_in, sense_key_out,
	input wire logic [2:0] lun_out
);
	// ****************************************************************
	// Message sequences
	// ****************************************************************
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	// Identify byte with reserved and routine-select bits clear
	sequence clean_id;
		ce_in && msg_valid_in && !conn_end_in && msg_byte_in[7] && msg_byte_in[5:3] == 3'h0;
	endsequence
	// Clean repeat naming the unit already held
	sequence same_unit;
		clean_id ##0 process_messages_out && msg_byte_in[2:0] == lun_out;
	endsequence
	// Command while a foreign unit is addressed
	sequence bad_cmd;
		ce_in && cmd_valid_in && process_messages_out && lun_out != 3'h0;
	endsequence

	// ****************************************************************
	// Properties
	// ****************************************************************
	first_accept_a: assert property (
		clean_id ##0 !process_messages_out && bus_phase_in == 4'h0 |=> process_messages_out
		&& disconnect_grant_bit_out == $past(msg_byte_in[6]) && lun_out == $past(msg_byte_in[2:0])
	) else $error("first identify not latched");
	select_grant_a: assert property (
		same_unit ##0 bus_phase_in == 4'h0 |=> disconnect_grant_bit_out == $past(msg_byte_in[6])
	) else $error("grant not updated in selection");
	invalid_flag_a: assert property (
		ce_in && msg_valid_in && !conn_end_in && msg_byte_in[7] && msg_byte_in[5:3] != 3'h0
		&& process_messages_out |=> invalid_identify_out && $stable(disconnect_grant_bit_out)
	) else $error("invalid identify not flagged");
	tx_grant_a: assert property (
		tx_identify_out == {5'h10, lun_out}
	) else $error("own identify byte wrong");
	hold_no_grant_a: assert property (
		process_messages_out && !disconnect_grant_bit_out |-> hold_connection_out && !disconnect_ok_out
	) else $error("bus released without grant");
	transfer_cont_a: assert property (
		same_unit ##0 bus_phase_in inside {[4'h1:4'h5]} |=> continue_out && !bus_free_out
		&& $stable(lun_out)
	) else $error("transfer phase repeat not continued");
	cmd_done_free_a: assert property (
		same_unit ##0 bus_phase_in == 4'h6 |=> bus_free_out && !continue_out
	) else $error("no bus free after completion");
	after_disc_a: assert property (
		same_unit ##0 bus_phase_in == 4'h7 |=> disconnect_grant_bit_out == $past(msg_byte_in[6])
		&& bus_free_out == disconnect_grant_bit_out && continue_out != disconnect_grant_bit_out
	) else $error("wrong reaction after disconnect");
	after_reply_a: assert property (
		same_unit ##0 bus_phase_in inside {[4'h8:4'hA]} |=> continue_out && !bus_free_out
		&& disconnect_grant_bit_out == $past(msg_byte_in[6])
	) else $error("wrong reaction after reply");
	bad_unit_a: assert property (
		bad_cmd ##0 cmd_opcode_in != 8'h12 && cmd_opcode_in != 8'h03 |=> check_condition_out
		&& sense_key_out == 4'h5 && sense_asc_out == 8'h25
	) else $error("foreign unit command not refused");
	inquiry_a: assert property (
		bad_cmd ##0 cmd_opcode_in == 8'h12 |=> inquiry_override_out && inquiry_byte0_out == 8'h7F
		&& !check_condition_out
	) else $error("foreign unit inquiry wrong");
endmodule
bind identify_message_handler identify_message_handler_props u_props (.*);
`default_nettype wire

// ### bench/initiator_model.sv
`timescale 1ns/1ps
`default_nettype none
module initiator_model (
	input  wire logic       clk_in,
	input  wire logic       req_in,
	input  wire logic [7:0] byte_in,
	input  wire logic [3:0] phase_in,
	input  wire logic       drop_in,
	output var  logic       msg_valid_out,
	output var  logic [7:0] msg_byte_out,
	output var  logic [3:0] bus_phase_out,
	output var  logic       conn_end_out
);
	// Bytes go out as asked, so a bad or foreign byte is always deliberate
	always @(posedge clk_in) begin
		msg_valid_out <= req_in;
		conn_end_out <= drop_in;
		bus_phase_out <= phase_in;
		if (req_in) begin
			msg_byte_out <= byte_in;
		end else begin
			msg_byte_out <= 8'h00; // Released data lines read as negated
		end
	end
endmodule
`default_nettype wire

// ### bench/identify_message_handler_test.sv
`timescale 1ns/1ps
`default_nettype none
module identify_message_handler_test;
	logic             sys_clk_in, rst_n_in, ce_in, req, drop;
	logic [2:0]       ev;
	logic [7:0]       pay, s_axi_awaddr, s_axi_araddr;
	logic [3:0]       phase, s_axi_wstrb;
	logic [31:0]      s_axi_wdata;
	logic             s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	integer           i, miscompares, samples_checked;
	wire logic        msg_valid_in, conn_end_in, cmd_valid_in, cmd_done_in, disc_taken_in;
	wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic        process_messages_out, disconnect_grant_bit_out, continue_out, irq_out;
	wire logic        bus_free_out, invalid_identify_out, lun_mismatch_out, check_condition_out;
	wire logic        inquiry_override_out, disconnect_ok_out, hold_connection_out;
	wire logic [1:0]  s_axi_bresp, s_axi_rresp;
	wire logic [2:0]  lun_out;
	wire logic [3:0]  bus_phase_in, sense_key_out;
	wire logic [7:0]  msg_byte_in, cmd_opcode_in, sense_asc_out, sense_ascq_out;
	wire logic [7:0]  inquiry_byte0_out, tx_identify_out;
	wire logic [31:0] s_axi_rdata;

	// Command strobes share one vector, opcode shares the payload
	assign {cmd_done_in, disc_taken_in, cmd_valid_in} = ev;
	assign cmd_opcode_in = pay;

	identify_message_handler u_dut (.*);
	initiator_model u_init (
		.clk_in        (sys_clk_in),
		.req_in        (req),
		.byte_in       (pay),
		.phase_in      (phase),
		.drop_in       (drop),
		.msg_valid_out (msg_valid_in),
		.msg_byte_out  (msg_byte_in),
		.bus_phase_out (bus_phase_in),
		.conn_end_out  (conn_end_in)
	);

	// ****************************************************************
	// Clock and helpers
	// ****************************************************************
	initial begin
		sys_clk_in = 1'b0;
		forever #2 sys_clk_in = ~sys_clk_in;
	end

	// Compare and count
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (seen !== exp) begin
				miscompares = miscompares + 1;
				$display("mismatch %s expected %h seen %h", what, exp, seen);
			end
		end
	endtask

	// Verdict and end of run
	task automatic close_out;
		begin
			$display("checks %0d mismatches %0d", samples_checked, miscompares);
			if (miscompares == 0 && samples_checked > 0) begin
				$display("bench passed");
			end else begin
				$display("bench failed");
			end
			$finish;
		end
	endtask

	// One register access; read data doubles as the expected word
	task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] er);
		integer n;
		begin
			s_axi_awaddr <= a;
			s_axi_araddr <= a;
			s_axi_wdata <= d;
			{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
			{s_axi_arvalid, s_axi_rready} <= {2{!wr}};
			n = 0;
			do begin
				@(posedge sys_clk_in);
				n = n + 1;
				if (s_axi_awready) s_axi_awvalid <= 1'b0;
				if (s_axi_wready) s_axi_wvalid <= 1'b0;
				if (s_axi_arready) s_axi_arvalid <= 1'b0;
			end while (!(wr ? s_axi_bvalid : s_axi_rvalid) && n < 40);
			{s_axi_bready, s_axi_rready} <= 2'h0;
			if (!(wr ? s_axi_bvalid : s_axi_rvalid)) begin
				miscompares = miscompares + 1;
				close_out();
			end
			chk("response", wr ? s_axi_bresp : s_axi_rresp, er);
			if (!wr) chk("read data", s_axi_rdata, d);
			#1;
		end
	endtask

	// Message or connection end goes via the initiator, one edge later
	task automatic step(input logic [4:0] k, input logic [7:0] b, input logic [3:0] ph);
		begin
			{req, drop, ev} <= k;
			pay <= b;
			phase <= ph;
			@(posedge sys_clk_in);
			{req, drop, ev} <= 5'h00;
			if (k[4:3] != 2'h0) begin
				@(posedge sys_clk_in);
			end
			#1;
		end
	endtask

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		miscompares = 0;
		samples_checked = 0;
		ce_in = 1'b1;
		rst_n_in = 1'b0;
		{req, drop, ev} = 5'h00;
		pay = 8'h00;
		phase = 4'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'hF;
		repeat (12) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		#1;
		// Defaults, then an unmapped read and an unmapped write
		axi(1'b0, 8'h00, 32'h0000_0001, 2'h0);
		axi(1'b0, 8'h0C, 32'h0000_0000, 2'h0);
		axi(1'b0, 8'h20, 32'h0000_0000, 2'h2);
		axi(1'b1, 8'h24, 32'h0000_00FF, 2'h2);
		$display("test registers done");
		// First identify, interrupt raised, masked and cleared
		step(5'h10, 8'hC0, 4'h0);
		chk("process", process_messages_out, 1'b1);
		chk("grant", disconnect_grant_bit_out, 1'b1);
		axi(1'b0, 8'h04, 32'h0000_0003, 2'h0);
		axi(1'b0, 8'h08, 32'h0000_0001, 2'h0);
		chk("irq masked", irq_out, 1'b0);
		axi(1'b1, 8'h0C, 32'h0000_0001, 2'h0);
		chk("irq raised", irq_out, 1'b1);
		axi(1'b1, 8'h08, 32'h0000_0001, 2'h0);
		chk("irq cleared", irq_out, 1'b0);
		step(5'h10, 8'h80, 4'h0);
		chk("grant", disconnect_grant_bit_out, 1'b0);
		chk("tx byte", tx_identify_out, 8'h80);
		axi(1'b0, 8'h04, 32'h0000_0005, 2'h0);
		chk("hold", hold_connection_out, 1'b1);
		step(5'h01, 8'h00, 4'h1);
		chk("unit zero command", check_condition_out, 1'b0);
		$display("test first identify done");
		// Repeats in transfer and reply phases, bad bytes, completion
		for (i = 1; i <= 10; i = i + 1) begin
			if (i != 6 && i != 7) begin
				step(5'h10, i[0] ? 8'hC0 : 8'h80, i[3:0]);
				chk("continue", continue_out, 1'b1);
				chk("no free", bus_free_out, 1'b0);
			end
		end
		chk("reply grant", disconnect_grant_bit_out, 1'b0);
		for (i = 0; i < 3; i = i + 1) begin
			step(5'h10, 8'hC0 | (8'h08 << i), 4'h1);
			chk("invalid", invalid_identify_out, 1'b1);
			chk("grant kept", disconnect_grant_bit_out, 1'b0);
		end
		step(5'h10, 8'h47, 4'h1);
		chk("not identify", {invalid_identify_out, continue_out, disconnect_grant_bit_out}, 3'h0);
		step(5'h10, 8'h80, 4'h6);
		chk("free after done", bus_free_out, 1'b1);
		$display("test repeats done");
		// New connection: one disconnect per command, identify after disconnect
		step(5'h08, 8'h00, 4'h0);
		chk("ended", process_messages_out, 1'b0);
		step(5'h10, 8'hC0, 4'h0);
		chk("may drop", disconnect_ok_out, 1'b1);
		step(5'h02, 8'h00, 4'h0);
		chk("used once", disconnect_ok_out, 1'b0);
		step(5'h04, 8'h00, 4'h0);
		chk("rearmed", disconnect_ok_out, 1'b1);
		step(5'h10, 8'h80, 4'h7);
		chk("stay", {continue_out, bus_free_out}, 2'h2);
		step(5'h10, 8'hC0, 4'h7);
		chk("go free", {bus_free_out, disconnect_grant_bit_out}, 2'h3);
		$display("test disconnect done");
		// Foreign unit: commands, inquiry, sense, change of unit
		step(5'h08, 8'h00, 4'h0);
		step(5'h10, 8'hC1, 4'h0);
		chk("unit", lun_out, 3'h1);
		chk("tx byte", tx_identify_out, 8'h81);
		step(5'h01, 8'h00, 4'h1);
		chk("check", check_condition_out, 1'b1);
		chk("sense", {sense_key_out, sense_asc_out, sense_ascq_out}, 20'h5_2500);
		step(5'h01, 8'h12, 4'h1);
		chk("inquiry", {inquiry_override_out, inquiry_byte0_out, check_condition_out}, 10'h2FE);
		step(5'h01, 8'h03, 4'h1);
		chk("request sense", {check_condition_out, sense_asc_out}, 9'h025);
		step(5'h10, 8'hC0, 4'h1);
		chk("unit change", {lun_mismatch_out, lun_out}, 4'h9);
		// Drop request, disabled handler, frozen clock enable
		axi(1'b1, 8'h00, 32'h0000_0003, 2'h0);
		chk("dropped", process_messages_out, 1'b0);
		axi(1'b1, 8'h00, 32'h0000_0000, 2'h0);
		step(5'h10, 8'hC8, 4'h0);
		chk("disabled", invalid_identify_out, 1'b0);
		axi(1'b1, 8'h00, 32'h0000_0001, 2'h0);
		ce_in <= 1'b0;
		step(5'h10, 8'hC8, 4'h0);
		chk("frozen", invalid_identify_out, 1'b0);
		ce_in <= 1'b1;
		step(5'h10, 8'hC8, 4'h0);
		chk("invalid first", invalid_identify_out, 1'b1);
		$display("test foreign unit done");
		close_out();
	end
endmodule
`default_nettype wire
